// file: rtl/two_wire_master.sv
// Overview of operation
// R1: Software starts a transfer writing control with flag, start, enable set, stop clear.
// R2: Enable must be set with every start, continue or stop command.
// R3: Writing one to the flag bit clears it; it is never stored.
// R4: A requested START waits until the bus is seen free.
// R5: After START the flag is set and status reads 0x08.
// R6: Address write bit selects transmit mode, read bit selects receive mode.
// R7: At 0x08 software loads address plus read bit, then clears flag.
// R8: Continue command: flag and enable set, start and stop clear.
// R9: After read address: 0x38 lost, 0x40 acknowledged, 0x48 not acknowledged.
// R10: Received byte is in the data register when the flag rises.
// R11: Software answers the last received byte with a not-acknowledge.
// R12: Stop command: flag, stop and enable set, start clear.
// R13: Repeated START reports 0x10 and keeps the bus owned.
// R14: Status code field is read with prescaler bits kept apart.
// R15: Transmit reports 0x20, 0x28, 0x30; continuing sends the loaded byte.
// R16: Flag cleared with start set, stop clear gives a repeated START.
// R17: Flag cleared with stop set sends STOP, then stop bit self-clears.
// R18: Start and stop both set: STOP then new START, stop self-clears.
// R19: Lost arbitration reports 0x38; clearing with start low releases the bus.
// R20: After lost arbitration, clearing with start set waits free bus then START.
// R21: All bus activity is suspended while the flag is set.
// R22: Data writes with the flag low are dropped and set write collision.
// R23: Write address acknowledged reports 0x18.
// R24: Received bytes are answered by ack-enable: one acknowledges, zero does not.
// R25: While the flag is set as master, SCL is held low.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module two_wire_master #(
   parameter int HALF_CYCLES = two_wire_pkg::HALF_BIT_CYCLES
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial clock pin, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   // Serial data pin, open drain
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);

   typedef struct packed {
      two_wire_pkg::master_state_type state;
      logic [two_wire_pkg::CNT_W-1:0] cnt;
      logic [3:0] bit_idx;
      logic [7:0] shift;
      logic [7:0] data;
      logic [7:0] status;
      logic [two_wire_pkg::PRESC_W-1:0] presc;
      logic flag;
      logic ack_en;
      logic start;
      logic stop;
      logic wcol;
      logic en;
      logic ie;
      logic owner;
      logic addr_phase;
      logic rx_mode;
      logic scl_low;
      logic sda_low;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } master_regs_type;

   master_regs_type s;
   master_regs_type next_s;

   logic scl_s;
   logic sda_s;
   logic bus_busy;
   logic tick;
   logic rx_byte;
   logic bit_val;
   logic drive_slot;
   logic acc_setup;
   logic acc_write;

   two_wire_pin_sync two_wire_pin_sync_i (
      .pclk(pclk),
      .presetn(presetn),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .bus_busy(bus_busy)
   );

   assign tick = (s.cnt == two_wire_pkg::CNT_W'(HALF_CYCLES - 1));
   assign rx_byte = s.rx_mode && !s.addr_phase;
   // Value put on SDA for the current bit slot; ones are released
   assign bit_val = (s.bit_idx < two_wire_pkg::LAST_BIT) ? (rx_byte | s.shift[7]) : (rx_byte ? !s.ack_en : 1'b1); // [R24]
   // Slots where the master drives, so a low read back means lost arbitration
   assign drive_slot = (s.bit_idx < two_wire_pkg::LAST_BIT) ? !rx_byte : rx_byte;
   assign acc_setup = psel && penable && !s.pready;
   assign acc_write = psel && penable && s.pready && pwrite;

   always_comb begin
      next_s = s;
      next_s.cnt = tick ? '0 : s.cnt + 1'b1;

      // APB: one wait state, read data and error registered with ready
      next_s.pready = acc_setup;
      next_s.pslverr = 1'b0;
      if (acc_setup) begin
         unique case (paddr)
            two_wire_pkg::CTRL_OFF: next_s.prdata = {24'h0000_00, s.flag, s.ack_en, s.start, s.stop,
                                                    s.wcol, s.en, 1'b0, s.ie};
            two_wire_pkg::STATUS_OFF: next_s.prdata = {24'h0000_00, s.status[7:two_wire_pkg::CODE_LSB],
                                                      1'b0, s.presc}; // [R14]
            two_wire_pkg::DATA_OFF: next_s.prdata = {24'h0000_00, s.data};
            default: begin
               next_s.prdata = 32'h0000_0000;
               next_s.pslverr = 1'b1;
            end
         endcase
      end

      if (acc_write) begin
         unique case (paddr)
            two_wire_pkg::CTRL_OFF: begin
               next_s.ack_en = pwdata[two_wire_pkg::ACK_EN_POS];
               next_s.start = pwdata[two_wire_pkg::START_POS];
               next_s.stop = pwdata[two_wire_pkg::STOP_POS];
               next_s.en = pwdata[two_wire_pkg::EN_POS]; // [R2]
               next_s.ie = pwdata[two_wire_pkg::IE_POS];
               if (pwdata[two_wire_pkg::FLAG_POS]) begin
                  next_s.flag = 1'b0; // [R3]
               end
            end
            two_wire_pkg::STATUS_OFF: next_s.presc = pwdata[two_wire_pkg::PRESC_LSB +: two_wire_pkg::PRESC_W];
            two_wire_pkg::DATA_OFF: begin
               if (s.flag) begin
                  next_s.data = pwdata[7:0];
                  next_s.wcol = 1'b0;
               end else begin
                  next_s.wcol = 1'b1; // [R22]
               end
            end
            default: ;
         endcase
      end

      // Bus engine; flag sets below override a same-cycle clear
      unique case (s.state)
         two_wire_pkg::S_IDLE: begin
            next_s.scl_low = 1'b0;
            next_s.sda_low = 1'b0;
            if (s.en && s.start && !s.flag) begin // [R1]
               next_s.state = two_wire_pkg::S_WAIT_FREE;
            end
         end
         two_wire_pkg::S_WAIT_FREE: begin
            next_s.cnt = '0;
            if (!bus_busy && scl_s && sda_s) begin // [R4] [R20]
               next_s.sda_low = 1'b1;
               next_s.state = two_wire_pkg::S_START_SDA;
            end
         end
         two_wire_pkg::S_START_SDA: begin
            if (tick) begin
               next_s.scl_low = 1'b1;
               next_s.state = two_wire_pkg::S_START_SCL;
            end
         end
         two_wire_pkg::S_START_SCL: begin
            if (tick) begin
               next_s.flag = 1'b1;
               next_s.status = s.owner ? two_wire_pkg::RSTART_SENT : two_wire_pkg::START_SENT; // [R5] [R13]
               next_s.owner = 1'b1;
               next_s.addr_phase = 1'b1;
               next_s.state = two_wire_pkg::S_HOLD;
            end
         end
         two_wire_pkg::S_HOLD: begin
            next_s.scl_low = 1'b1; // [R25]
            next_s.cnt = '0;
            if (!s.flag) begin // [R21]
               if (s.stop) begin
                  next_s.sda_low = 1'b1; // [R17] [R18]
                  next_s.state = two_wire_pkg::S_STOP_LOW;
               end else if (s.start) begin
                  next_s.sda_low = 1'b0; // [R16]
                  next_s.state = two_wire_pkg::S_RS_LOW;
               end else begin
                  next_s.bit_idx = 4'h0;
                  next_s.shift = s.data; // [R15] [R8]
                  if (s.addr_phase) begin
                     next_s.rx_mode = s.data[0]; // [R6] [R7]
                  end
                  next_s.state = two_wire_pkg::S_BIT_LOW;
               end
            end
         end
         two_wire_pkg::S_BIT_LOW: begin
            next_s.scl_low = 1'b1;
            next_s.sda_low = !bit_val; // [R11]
            if (tick) begin
               next_s.scl_low = 1'b0;
               next_s.state = two_wire_pkg::S_BIT_HIGH;
            end
         end
         two_wire_pkg::S_BIT_HIGH: begin
            // A slave stretching SCL holds the count at zero
            if (!scl_s) begin
               next_s.cnt = '0;
            end else if (tick) begin
               if (bit_val && drive_slot && !sda_s) begin
                  next_s.scl_low = 1'b0;
                  next_s.sda_low = 1'b0;
                  next_s.flag = 1'b1;
                  next_s.status = two_wire_pkg::ARB_LOST; // [R9] [R19]
                  next_s.owner = 1'b0;
                  next_s.state = two_wire_pkg::S_LOST;
               end else if (s.bit_idx < two_wire_pkg::LAST_BIT) begin
                  next_s.shift = {s.shift[6:0], sda_s};
                  next_s.bit_idx = s.bit_idx + 4'h1;
                  next_s.scl_low = 1'b1;
                  next_s.state = two_wire_pkg::S_BIT_LOW;
               end else begin
                  next_s.scl_low = 1'b1;
                  next_s.sda_low = 1'b0;
                  next_s.flag = 1'b1;
                  next_s.state = two_wire_pkg::S_HOLD;
                  if (s.addr_phase) begin
                     next_s.addr_phase = 1'b0;
                     if (s.rx_mode) begin
                        next_s.status = sda_s ? two_wire_pkg::AR_NACKED : two_wire_pkg::AR_ACKED; // [R9]
                     end else begin
                        next_s.status = sda_s ? two_wire_pkg::AW_NACKED : two_wire_pkg::AW_ACKED; // [R23]
                     end
                  end else if (s.rx_mode) begin
                     next_s.data = s.shift; // [R10]
                     next_s.status = s.ack_en ? two_wire_pkg::DR_ACKED : two_wire_pkg::DR_NACKED; // [R24]
                  end else begin
                     next_s.status = sda_s ? two_wire_pkg::DW_NACKED : two_wire_pkg::DW_ACKED; // [R15]
                  end
               end
            end
         end
         two_wire_pkg::S_LOST: begin
            next_s.scl_low = 1'b0;
            next_s.sda_low = 1'b0;
            if (!s.flag) begin
               next_s.state = s.start ? two_wire_pkg::S_WAIT_FREE : two_wire_pkg::S_IDLE; // [R19] [R20]
            end
         end
         two_wire_pkg::S_STOP_LOW: begin
            if (tick) begin
               next_s.scl_low = 1'b0;
               next_s.state = two_wire_pkg::S_STOP_HIGH;
            end
         end
         two_wire_pkg::S_STOP_HIGH: begin
            if (!scl_s) begin
               next_s.cnt = '0;
            end else if (tick) begin
               next_s.sda_low = 1'b0;
               next_s.state = two_wire_pkg::S_STOP_END;
            end
         end
         two_wire_pkg::S_STOP_END: begin
            if (tick) begin
               next_s.stop = 1'b0; // [R17]
               next_s.owner = 1'b0;
               next_s.status = two_wire_pkg::NO_INFO;
               next_s.state = s.start ? two_wire_pkg::S_WAIT_FREE : two_wire_pkg::S_IDLE; // [R18]
            end
         end
         two_wire_pkg::S_RS_LOW: begin
            if (tick) begin
               next_s.scl_low = 1'b0;
               next_s.state = two_wire_pkg::S_RS_HIGH;
            end
         end
         two_wire_pkg::S_RS_HIGH: begin
            if (!scl_s) begin
               next_s.cnt = '0;
            end else if (tick) begin
               next_s.sda_low = 1'b1; // [R13]
               next_s.state = two_wire_pkg::S_START_SDA;
            end
         end
         default: next_s.state = two_wire_pkg::S_IDLE;
      endcase

      // Disabled interface lets go of the bus at once
      if (!s.en) begin
         next_s.state = two_wire_pkg::S_IDLE;
         next_s.scl_low = 1'b0;
         next_s.sda_low = 1'b0;
         next_s.owner = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{state: two_wire_pkg::S_IDLE, cnt: '0, bit_idx: 4'h0, shift: 8'h00,
                data: two_wire_pkg::DATA_RESET, status: two_wire_pkg::NO_INFO, presc: '0,
                flag: 1'b0, ack_en: 1'b0, start: 1'b0, stop: 1'b0, wcol: 1'b0, en: 1'b0, ie: 1'b0,
                owner: 1'b0, addr_phase: 1'b0, rx_mode: 1'b0, scl_low: 1'b0, sda_low: 1'b0,
                pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign scl_out = 1'b0;
   assign scl_oe = s.scl_low;
   assign sda_out = 1'b0;
   assign sda_oe = s.sda_low;

endmodule : two_wire_master

// file: rtl/two_wire_pkg.sv
package two_wire_pkg;

   // Bit timing
   localparam int CLK_FREQ_MHZ = 10;
   localparam int HALF_BIT_NS = 5000;
   localparam int HALF_BIT_CYCLES = (HALF_BIT_NS * CLK_FREQ_MHZ) / 1000;
   localparam int CNT_W = 16;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] DATA_OFF = 8'h08;

   // Control register fields
   localparam int FLAG_POS = 7;
   localparam int ACK_EN_POS = 6;
   localparam int START_POS = 5;
   localparam int STOP_POS = 4;
   localparam int WCOL_POS = 3;
   localparam int EN_POS = 2;
   localparam int IE_POS = 0;

   // Status register fields
   localparam int CODE_LSB = 3;
   localparam int PRESC_LSB = 0;
   localparam int PRESC_W = 2;

   // Status codes, prescaler bits zero
   localparam logic [7:0] START_SENT = 8'h08;
   localparam logic [7:0] RSTART_SENT = 8'h10;
   localparam logic [7:0] AW_ACKED = 8'h18;
   localparam logic [7:0] AW_NACKED = 8'h20;
   localparam logic [7:0] DW_ACKED = 8'h28;
   localparam logic [7:0] DW_NACKED = 8'h30;
   localparam logic [7:0] ARB_LOST = 8'h38;
   localparam logic [7:0] AR_ACKED = 8'h40;
   localparam logic [7:0] AR_NACKED = 8'h48;
   localparam logic [7:0] DR_ACKED = 8'h50;
   localparam logic [7:0] DR_NACKED = 8'h58;
   localparam logic [7:0] NO_INFO = 8'hF8;

   localparam logic [7:0] DATA_RESET = 8'hFF;
   localparam logic [3:0] LAST_BIT = 4'h8;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0000,
      S_WAIT_FREE = 4'b0001,
      S_START_SDA = 4'b0011,
      S_START_SCL = 4'b0010,
      S_HOLD = 4'b0110,
      S_BIT_LOW = 4'b0111,
      S_BIT_HIGH = 4'b0101,
      S_LOST = 4'b0100,
      S_STOP_LOW = 4'b1100,
      S_STOP_HIGH = 4'b1101,
      S_STOP_END = 4'b1111,
      S_RS_LOW = 4'b1110,
      S_RS_HIGH = 4'b1010
   } master_state_type;

endpackage : two_wire_pkg

// file: rtl/two_wire_pin_sync.sv
`timescale 1ns/1ps
module two_wire_pin_sync (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   // Synchronised view
   output logic scl_s,
   output logic sda_s,
   output logic bus_busy
);

   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] sync;
      logic [1:0] prev;
      logic busy;
   } sync_state_type;

   sync_state_type s;
   sync_state_type next_s;

   always_comb begin
      next_s = s;
      next_s.meta = {scl_in, sda_in};
      next_s.sync = s.meta;
      next_s.prev = s.sync;
      // Falling SDA with SCL high is a START, rising is a STOP
      if (s.sync[1] && s.prev[1] && !s.sync[0] && s.prev[0]) begin
         next_s.busy = 1'b1;
      end else if (s.sync[1] && s.prev[1] && s.sync[0] && !s.prev[0]) begin
         next_s.busy = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{meta: 2'b11, sync: 2'b11, prev: 2'b11, busy: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign scl_s = s.sync[1];
   assign sda_s = s.sync[0];
   assign bus_busy = s.busy;

endmodule : two_wire_pin_sync

// file: dv/two_wire_properties.sv
`timescale 1ns/1ps
module two_wire_checker #(
   parameter int HALF_CYCLES = 4
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Bus pins
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic mapped;
   assign mapped = paddr inside {8'h00, 8'h04, 8'h08};
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered after one wait");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("pready without access");
   a_err_unmapped: assert property (pready && !mapped |-> pslverr)
      else $error("unmapped access not refused");
   a_err_mapped: assert property (pready && mapped |-> !pslverr)
      else $error("mapped access refused");
   a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   a_pins_low: assert property (!scl_out && !sda_out)
      else $error("open drain output not low");
   a_start_order: assert property ($rose(sda_oe) && !scl_oe |->
      (sda_oe && !scl_oe) [*3] ##[1:HALF_CYCLES] (sda_oe && scl_oe))
      else $error("start condition out of order");
   a_stop_release: assert property ($fell(sda_oe) && !scl_oe |=> !scl_oe [*3])
      else $error("clock pulled right after stop");
   cover property (pready && pslverr);
   cover property (pready && !pwrite);
   cover property ($rose(sda_oe) && !scl_oe);
   cover property ($fell(sda_oe) && !scl_oe);
endmodule : two_wire_checker

bind two_wire_master two_wire_checker #(.HALF_CYCLES(HALF_CYCLES)) two_wire_checker_i (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_in, .scl_out, .scl_oe,
   .sda_in, .sda_out, .sda_oe);

// file: dv/two_wire_slave_model.sv
`timescale 1ns/1ps
module two_wire_slave_model #(
   parameter logic [6:0] ADDR = 7'h50
) (
   // Bus wires
   input wire logic scl,
   input wire logic sda,
   input wire logic slow,
   output logic scl_pull,
   output logic sda_pull,
   // Byte traffic
   output logic [7:0] last_byte,
   input wire logic [7:0] tx_byte
);
   int cnt = -1;
   logic [7:0] sh = 8'h00;
   logic hit = 0, rd = 0, adr = 0;
   initial begin
      scl_pull = 0;
      sda_pull = 0;
      last_byte = 8'h00;
   end
   // START and STOP are SDA edges while SCL is high
   always @(negedge sda) if (scl) begin
      cnt = -1;
      adr = 1;
      hit = 0;
   end
   always @(posedge sda) if (scl) hit = 0;
   always @(posedge scl) begin
      if (cnt >= 0 && cnt < 8) sh = {sh[6:0], sda};
      if (cnt == 8 && rd && !adr && sda) hit = 0;
   end
   // Data changes only while SCL is low
   always @(negedge scl) begin
      #50;
      if (cnt == 8) begin
         cnt = 0;
         adr = 0;
      end else cnt++;
      if (cnt == 8 && adr) begin
         hit = sh[7:1] == ADDR;
         rd = sh[0];
      end
      if (cnt == 8 && hit && !rd && !adr) last_byte = sh;
      if (cnt == 8) sda_pull = hit && (adr || !rd);
      else sda_pull = hit && rd && !adr && !tx_byte[7 - cnt];
      if (slow) begin
         scl_pull = 1;
         #1500;
         scl_pull = 0;
      end
   end
endmodule : two_wire_slave_model

// file: dv/two_wire_master_test.sv
`timescale 1ns/1ps
module two_wire_master_test;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rdv;
   logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, err;
   logic scl_pull, sda_pull, other_pull = 0, slow = 0;
   logic [7:0] last_byte, d, tx_byte = 8'h00;
   wire logic scl_w, sda_w;
   int failures = 0, checked = 0;
   // Bytes the slave must have taken, oldest first
   logic [7:0] sent_q [$];
   logic [31:0] rv [4] = '{32'h0000_0000, 32'(two_wire_pkg::NO_INFO), 32'(two_wire_pkg::DATA_RESET),
      32'h0000_0000};
   // Control, data, expected status
   logic [23:0] seq [13] = '{24'hA4_0008, 24'h84_A018, 24'h84_0028, 24'hA4_0010, 24'h84_A140, 24'hC4_0050,
      24'h84_0058, 24'hB4_0008, 24'h84_B020, 24'h84_0030, 24'hA4_0010, 24'h84_B148, 24'h94_00F8};
   assign scl_w = (scl_oe ? scl_out : 1'b1) & !scl_pull;
   assign sda_w = (sda_oe ? sda_out : 1'b1) & !sda_pull & !other_pull;
   always #50 pclk = ~pclk;
   two_wire_master #(.HALF_CYCLES(4)) two_wire_master_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .scl_in(scl_w), .scl_out, .scl_oe, .sda_in(sda_w), .sda_out, .sda_oe);
   two_wire_slave_model two_wire_slave_model_i (.scl(scl_w), .sda(sda_w), .slow, .scl_pull, .sda_pull,
      .last_byte, .tx_byte);
   task final_report;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
      int n;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 50) begin
         failures++;
         final_report();
      end
   endtask : apb
   task automatic wait_chk(input logic [7:0] e);
      int n;
      logic [31:0] r;
      n = 0;
      do begin
         apb(0, 8'h00, 0, r);
         n++;
      end while ((e == 8'hF8 ? r[4] : !r[7]) && n < 400);
      apb(0, 8'h04, 0, r);
      if (n >= 400) begin
         failures++;
         final_report();
      end else begin
         chk("status", 32'(e), r & 32'h0000_00F8);
         if (e != 8'hF8) begin
            repeat (8) @(posedge pclk);
            chk("scl_hold", 32'(e != 8'h38), 32'(scl_oe));
         end
      end
   endtask : wait_chk
   initial begin
      void'($urandom(75742));
      tx_byte = 8'($urandom);
      repeat (6) @(posedge pclk);
      presetn <= 1;
      for (int i = 0; i < 4; i++) begin
         apb(0, 8'(4 * i), 0, rdv);
         chk("reset_val", rv[i], rdv);
         chk("slverr", 32'(i == 3), 32'(err));
      end
      apb(1, 8'h00, 32'h0000_00C3, rdv);
      apb(0, 8'h00, 0, rdv);
      chk("flag_write", 32'h0000_0041, rdv);
      apb(1, 8'h04, 32'h0000_0003, rdv);
      apb(0, 8'h04, 0, rdv);
      chk("prescaler", 32'h0000_00FB, rdv);
      apb(1, 8'h04, 0, rdv);
      apb(1, 8'h08, 32'h0000_005A, rdv);
      apb(0, 8'h00, 0, rdv);
      chk("collision", 32'h0000_0008, rdv & 32'h0000_0008);
      apb(0, 8'h08, 0, rdv);
      chk("data_kept", 32'h0000_00FF, rdv);
      for (int i = 0; i < 13; i++) begin
         d = (i == 2 || i == 9) ? 8'($urandom) : seq[i][15:8];
         slow <= 1'($urandom);
         if (i > 0) apb(1, 8'h08, 32'(d), rdv);
         if (i == 2) sent_q.push_back(d);
         apb(1, 8'h00, 32'(seq[i][23:16]), rdv);
         wait_chk(seq[i][7:0]);
         if (i == 2) chk("slave_rx", 32'(sent_q.pop_front()), 32'(last_byte));
         if (i == 5 || i == 6) begin
            apb(0, 8'h08, 0, rdv);
            chk("rx_data", 32'(tx_byte), rdv);
         end
      end
      apb(1, 8'h00, 32'h0000_00A4, rdv);
      wait_chk(8'h08);
      apb(1, 8'h08, 32'h0000_00A0, rdv);
      apb(1, 8'h00, 32'h0000_0084, rdv);
      other_pull <= 1;
      wait_chk(8'h38);
      apb(1, 8'h00, 32'h0000_00A4, rdv);
      repeat (20) @(posedge pclk);
      chk("wait_free", 32'h0000_0000, 32'(sda_oe));
      other_pull <= 0;
      wait_chk(8'h08);
      apb(1, 8'h00, 32'h0000_0094, rdv);
      wait_chk(8'hF8);
      final_report();
   end
endmodule : two_wire_master_test
